//--- logic/cmp_event_pkg.sv
package cmp_event_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL0_OFFSET  = 8'h00;
	localparam logic [7:0] CTRL1_OFFSET  = 8'h04;
	localparam logic [7:0] CTRL2_OFFSET  = 8'h08;
	localparam logic [7:0] CTRL3_OFFSET  = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET = 8'h10;

	// ------------------------------------------------------------
	// control field positions and codes
	// ------------------------------------------------------------
	localparam int ENABLE_BIT  = 7;
	localparam int IRQ_EN_BIT  = 6;
	localparam int SENSE_LSB   = 4;
	localparam int AUX_BIT     = 3;
	localparam int FLAG_LSB    = 4;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] NO_AUX_MASK   = 8'hF7;
	localparam logic [3:0] FLAGS_RESET   = 4'h0;
	localparam logic [1:0] SENSE_TOGGLE  = 2'h0;
	localparam logic [1:0] SENSE_FALL    = 2'h2;
	localparam logic [1:0] SENSE_RISE    = 2'h3;
	localparam logic [2:0] NEG_BANDGAP   = 3'h4;
	localparam logic [2:0] NEG_DAC       = 3'h5;
	localparam logic [2:0] NEG_PIN       = 3'h6;
	localparam logic [2:0] NEG_RESERVED  = 3'h7;
	localparam logic [3:0] NC_ALL_HIGH   = 4'hF;
	localparam logic [3:0] NC_ALL_LOW    = 4'h0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic [3:0][7:0] ctrl;
		logic [3:0]      flags;
		logic [3:0]      out;
		logic [3:0]      irq;
		logic [3:0]      trig;
		logic [3:0]      en_out;
		logic [3:0][2:0] neg_sel;
		logic            clk_sel;
		logic            cap_src;
		logic [3:0]      cap_hist;
		logic            cap_filt;
		logic            cap_event;
		logic            cap_irq;
		apb_rsp_s        rsp;
	} state_s;
endpackage

//--- logic/comparator_event_control.sv
module comparator_event_control (
	input  wire logic                     core_clk,
	input  wire logic                     arst_n,
	input  wire cmp_event_pkg::apb_req_s  apb_req,
	output      cmp_event_pkg::apb_rsp_s  apb_rsp,
	input  wire logic [3:0]               cmp_decision,
	input  wire logic [3:0]               vector_ack,
	input  wire logic                     capture_irq_mask,
	input  wire logic                     capture_edge_select,
	input  wire logic                     capture_noise_cancel,
	output      logic [3:0]               cmp_enable,
	output      logic [3:0][2:0]          cmp_neg_sel,
	output      logic                     cmp_clock_select,
	output      logic [3:0]               cmp_irq,
	output      logic [3:0]               conv_trigger,
	output      logic                     capture_input,
	output      logic                     capture_event,
	output      logic                     capture_irq
);
	cmp_event_pkg::state_s st_reg;
	cmp_event_pkg::state_s st_next;
	logic [3:0]            new_out;
	logic [3:0]            ev;
	logic [3:0]            w1c;
	logic [3:0]            ie_vec;
	logic [3:0]            en_vec;
	logic [7:0]            rd_byte;
	logic                  rd_err;
	logic                  apb_load;
	logic                  apb_fire;
	logic                  link;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_next  = st_reg;
		w1c      = 4'h0;
		rd_byte  = 8'h00;
		rd_err   = 1'b0;
		link     = st_reg.ctrl[1][cmp_event_pkg::AUX_BIT];
		apb_load = apb_req.psel & apb_req.penable & ~st_reg.rsp.pready;
		apb_fire = apb_req.psel & apb_req.penable & st_reg.rsp.pready;
		for (int i = 0; i < 4; i++) begin
			en_vec[i] = st_reg.ctrl[i][cmp_event_pkg::ENABLE_BIT];
			ie_vec[i] = st_reg.ctrl[i][cmp_event_pkg::IRQ_EN_BIT];
		end
		// sample the clocked comparators; reserved mux code yields low
		for (int i = 0; i < 4; i++) begin
			new_out[i] = en_vec[i] & cmp_decision[i]
				& (st_reg.ctrl[i][2:0] != cmp_event_pkg::NEG_RESERVED);
		end
		// edge detect per comparator against its own sense field
		for (int i = 0; i < 4; i++) begin
			case (st_reg.ctrl[i][cmp_event_pkg::SENSE_LSB +: 2])
				cmp_event_pkg::SENSE_TOGGLE: ev[i] = new_out[i] ^ st_reg.out[i];
				cmp_event_pkg::SENSE_FALL:   ev[i] = ~new_out[i] & st_reg.out[i];
				cmp_event_pkg::SENSE_RISE:   ev[i] = new_out[i] & ~st_reg.out[i];
				default:                     ev[i] = 1'b0;
			endcase
		end
		// address decode, shared by read and write
		if (apb_req.paddr == cmp_event_pkg::CTRL0_OFFSET) begin
			rd_byte = st_reg.ctrl[0];
		end else if (apb_req.paddr == cmp_event_pkg::CTRL1_OFFSET) begin
			rd_byte = st_reg.ctrl[1];
		end else if (apb_req.paddr == cmp_event_pkg::CTRL2_OFFSET) begin
			rd_byte = st_reg.ctrl[2] & cmp_event_pkg::NO_AUX_MASK;
		end else if (apb_req.paddr == cmp_event_pkg::CTRL3_OFFSET) begin
			rd_byte = st_reg.ctrl[3] & cmp_event_pkg::NO_AUX_MASK;
		end else if (apb_req.paddr == cmp_event_pkg::STATUS_OFFSET) begin
			rd_byte = {st_reg.flags, st_reg.out};
		end else begin
			rd_err = 1'b1;
		end
		// writes land only at the completing edge
		if (apb_fire && apb_req.pwrite && !rd_err) begin
			if (apb_req.paddr == cmp_event_pkg::STATUS_OFFSET) begin
				w1c = apb_req.pwdata[cmp_event_pkg::FLAG_LSB +: 4];
			end else if (apb_req.paddr == cmp_event_pkg::CTRL0_OFFSET) begin
				st_next.ctrl[0] = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == cmp_event_pkg::CTRL1_OFFSET) begin
				st_next.ctrl[1] = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == cmp_event_pkg::CTRL2_OFFSET) begin
				st_next.ctrl[2] = apb_req.pwdata[7:0] & cmp_event_pkg::NO_AUX_MASK;
			end else begin
				st_next.ctrl[3] = apb_req.pwdata[7:0] & cmp_event_pkg::NO_AUX_MASK;
			end
		end
		// one wait state so read data can come from a flop
		st_next.rsp.pready  = apb_load;
		st_next.rsp.pslverr = apb_load & rd_err;
		if (apb_load) begin
			st_next.rsp.prdata = {24'h000000, rd_byte};
		end
		// set wins over both clears so no event is lost
		st_next.out   = new_out;
		st_next.flags = (st_reg.flags & ~(w1c | (vector_ack & ie_vec))) | ev;
		for (int i = 0; i < 4; i++) begin
			st_next.irq[i]     = st_next.flags[i] & st_next.ctrl[i][cmp_event_pkg::IRQ_EN_BIT];
			st_next.en_out[i]  = st_next.ctrl[i][cmp_event_pkg::ENABLE_BIT];
			st_next.neg_sel[i] = st_next.ctrl[i][2:0];
		end
		st_next.trig    = st_next.flags;
		st_next.clk_sel = st_next.ctrl[0][cmp_event_pkg::AUX_BIT];
		// capture path: filter, then edge select, then mask
		st_next.cap_src  = link & st_reg.out[1];
		st_next.cap_hist = {st_reg.cap_hist[2:0], st_reg.cap_src};
		if (!link) begin
			// nothing of the comparator may leak once unlinked
			st_next.cap_hist = cmp_event_pkg::NC_ALL_LOW;
			st_next.cap_filt = 1'b0;
		end else if (!capture_noise_cancel) begin
			st_next.cap_filt = st_reg.cap_src;
		end else if (st_reg.cap_hist == cmp_event_pkg::NC_ALL_HIGH) begin
			st_next.cap_filt = 1'b1;
		end else if (st_reg.cap_hist == cmp_event_pkg::NC_ALL_LOW) begin
			st_next.cap_filt = 1'b0;
		end
		if (capture_edge_select) begin
			st_next.cap_event = link & st_next.cap_filt & ~st_reg.cap_filt;
		end else begin
			st_next.cap_event = link & ~st_next.cap_filt & st_reg.cap_filt;
		end
		st_next.cap_irq = st_next.cap_event & capture_irq_mask;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg       <= '0;
			st_reg.ctrl  <= {4{cmp_event_pkg::CTRL_RESET}};
			st_reg.flags <= cmp_event_pkg::FLAGS_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign apb_rsp          = st_reg.rsp;
	assign cmp_enable       = st_reg.en_out;
	assign cmp_neg_sel      = st_reg.neg_sel;
	assign cmp_clock_select = st_reg.clk_sel;
	assign cmp_irq          = st_reg.irq;
	assign conv_trigger     = st_reg.trig;
	assign capture_input    = st_reg.cap_src;
	assign capture_event    = st_reg.cap_event;
	assign capture_irq      = st_reg.cap_irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_capture_route;
		link |=> (capture_input == $past(st_reg.out[1]));
	endproperty
	a_capture_route: assert property (p_capture_route) else $error("capture input not routed");

	property p_capture_filter;
		$rose(st_reg.cap_filt) && $past(capture_noise_cancel) && $past(link)
			|-> $past(capture_input, 2) && $past(capture_input, 3)
			&& $past(capture_input, 4) && $past(capture_input, 5);
	endproperty
	a_capture_filter: assert property (p_capture_filter) else $error("filter passed short pulse");

	property p_capture_mask;
		capture_irq == (capture_event && $past(capture_irq_mask));
	endproperty
	a_capture_mask: assert property (p_capture_mask) else $error("capture irq mask ignored");

	property p_capture_edge;
		$past(link) && (($rose(st_reg.cap_filt) && $past(capture_edge_select))
			|| ($fell(st_reg.cap_filt) && !$past(capture_edge_select))) |-> capture_event;
	endproperty
	a_capture_edge: assert property (p_capture_edge) else $error("capture edge missed");

	property p_capture_cut;
		!link |=> !capture_input && !capture_event && !capture_irq;
	endproperty
	a_capture_cut: assert property (p_capture_cut) else $error("capture leaks when unlinked");

	property p_neg_sel;
		##1 cmp_neg_sel == {$past(st_reg.ctrl[3][2:0]), $past(st_reg.ctrl[2][2:0]),
			$past(st_reg.ctrl[1][2:0]), $past(st_reg.ctrl[0][2:0])} || $past(apb_fire);
	endproperty
	a_neg_sel: assert property (p_neg_sel) else $error("negative select mismatch");

	property p_enable_gate;
		##1 (st_reg.out & ~$past(en_vec)) == 4'h0;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("disabled comparator output high");

	property p_irq_request;
		cmp_irq == (st_reg.flags & {st_reg.ctrl[3][6], st_reg.ctrl[2][6], st_reg.ctrl[1][6], st_reg.ctrl[0][6]});
	endproperty
	a_irq_request: assert property (p_irq_request) else $error("irq not flag and enable");

	property p_aux_zero;
		apb_rsp.pready && !apb_req.pwrite && (apb_req.paddr == cmp_event_pkg::CTRL2_OFFSET
			|| apb_req.paddr == cmp_event_pkg::CTRL3_OFFSET) |-> !apb_rsp.prdata[3];
	endproperty
	a_aux_zero: assert property (p_aux_zero) else $error("reserved bit reads one");

	property p_status_read;
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == cmp_event_pkg::STATUS_OFFSET
			|-> apb_rsp.prdata == {24'h000000, $past(st_reg.flags), $past(st_reg.out)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status layout wrong");

	property p_trigger;
		conv_trigger == st_reg.flags && $stable(st_reg.trig) == $stable(st_reg.flags);
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger differs from flags");

	property p_clock_select;
		##1 cmp_clock_select == $past(st_reg.ctrl[0][3]) || $past(apb_fire);
	endproperty
	a_clock_select: assert property (p_clock_select) else $error("clock select mismatch");

	for (genvar g = 0; g < 4; g++) begin : g_chk
		property p_sample;
			##1 st_reg.out[g] == $past(en_vec[g] && cmp_decision[g] && st_reg.ctrl[g][2:0] != 3'h7);
		endproperty
		a_sample: assert property (p_sample) else $error("output sample wrong");

		property p_rise_flag;
			$rose(st_reg.out[g]) && $past(st_reg.ctrl[g][5:4]) == 2'h3 |-> st_reg.flags[g];
		endproperty
		a_rise_flag: assert property (p_rise_flag) else $error("rising event not flagged");

		property p_fall_flag;
			$fell(st_reg.out[g]) && $past(st_reg.ctrl[g][5:4]) != 2'h3
				&& $past(st_reg.ctrl[g][5:4]) != 2'h1 |-> st_reg.flags[g];
		endproperty
		a_fall_flag: assert property (p_fall_flag) else $error("falling event not flagged");

		property p_vector_clear;
			vector_ack[g] && ie_vec[g] && !ev[g] |=> !st_reg.flags[g];
		endproperty
		a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear flag");

		property p_w1c;
			w1c[g] && !ev[g] |=> !st_reg.flags[g];
		endproperty
		a_w1c: assert property (p_w1c) else $error("write one did not clear");

		property p_set_wins;
			ev[g] |=> st_reg.flags[g];
		endproperty
		a_set_wins: assert property (p_set_wins) else $error("event lost");
	end
endmodule

//--- dv/cmp_frontend_model.sv
module cmp_frontend_model #(
	parameter logic [7:0] REF_0     = 8'h20,
	parameter logic [7:0] REF_1     = 8'h40,
	parameter logic [7:0] REF_2     = 8'h60,
	parameter logic [7:0] REF_3     = 8'h80,
	parameter logic [7:0] BANDGAP   = 8'h50,
	parameter logic [7:0] DAC_LEVEL = 8'hA0
) (
	input  wire logic [3:0][2:0] neg_sel,
	input  wire logic [7:0]      neg_pin,
	input  wire logic [3:0][7:0] pos_level,
	output      logic [3:0]      decision
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] neg;
	// analog decision; reserved code compares against ground, so the block must mask it
	always_comb begin
		neg = 8'h00;
		for (int i = 0; i < 4; i++) begin
			case (neg_sel[i])
				3'h0: neg = REF_0;
				3'h1: neg = REF_1;
				3'h2: neg = REF_2;
				3'h3: neg = REF_3;
				3'h4: neg = BANDGAP;
				3'h5: neg = DAC_LEVEL;
				3'h6: neg = neg_pin;
				default: neg = 8'h00;
			endcase
			decision[i] = pos_level[i] > neg;
		end
	end
endmodule

//--- dv/tb.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    core_clk = 0;
	logic                    arst_n = 0;
	cmp_event_pkg::apb_req_s req = '0;
	cmp_event_pkg::apb_rsp_s rsp;
	logic [3:0]              dec;
	logic [3:0]              vack = '0;
	logic                    mask = 0;
	logic                    edge_sel = 0;
	logic                    nc = 0;
	logic [3:0]              en;
	logic [3:0][2:0]         nsel;
	logic [3:0]              irq;
	logic [3:0]              trig;
	logic                    cap_in;
	logic                    cap_ev;
	logic                    cap_irq;
	logic                    clk_sel;
	logic [3:0][7:0]         pos = '0;
	int                      bad_count = 0;
	int                      n_checks = 0;
	int                      cyc = 0;
	int                      ev_cnt = 0;
	int                      irq_cnt = 0;
	logic [31:0]             q;
	logic                    e;
	localparam logic [7:0]   ST = cmp_event_pkg::STATUS_OFFSET;

	comparator_event_control comparator_event_control_i (.core_clk(core_clk), .arst_n(arst_n), .apb_req(req),
		.apb_rsp(rsp), .cmp_decision(dec), .vector_ack(vack), .capture_irq_mask(mask),
		.capture_edge_select(edge_sel), .capture_noise_cancel(nc), .cmp_enable(en), .cmp_neg_sel(nsel),
		.cmp_clock_select(clk_sel), .cmp_irq(irq), .conv_trigger(trig), .capture_input(cap_in),
		.capture_event(cap_ev), .capture_irq(cap_irq));
	cmp_frontend_model cmp_frontend_model_i (.neg_sel(nsel), .neg_pin(8'h10), .pos_level(pos), .decision(dec));

	always #2 core_clk = ~core_clk;
	// pulse counters sampled mid-cycle, away from the launching edge
	always @(negedge core_clk) begin
		ev_cnt += (cap_ev === 1'b1);
		irq_cnt += (cap_irq === 1'b1);
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// bus and stimulus helpers
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= '{psel: 1, penable: 0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
		@(posedge core_clk);
		req.penable <= 1;
		// no fixed latency assumed: pready is looked at on the edge where the write lands
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		// a slave that never answers counts as a mismatch
		if (rsp.pready !== 1'b1) begin
			bad_count++;
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 0;
		req.penable <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 8'h00);
		`CHK("prdata", x, q)
	endtask
	task automatic set_pos(input int c, input logic [7:0] v);
		@(posedge core_clk);
		pos[c] <= v;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic ack(input logic [3:0] v);
		@(posedge core_clk);
		vack <= v;
		@(posedge core_clk);
		vack <= '0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
		apb(0, 8'h14, 8'h00);
		`CHK("unmapped err", 1'b1, e)
		apb(1, cmp_event_pkg::CTRL2_OFFSET, 8'hFF);
		rd(cmp_event_pkg::CTRL2_OFFSET, 32'hF7);
		`CHK("enable2", 1'b1, en[2])
		apb(1, cmp_event_pkg::CTRL3_OFFSET, 8'hFF);
		rd(cmp_event_pkg::CTRL3_OFFSET, 32'hF7);
		apb(1, cmp_event_pkg::CTRL3_OFFSET, 8'h00);
		apb(1, cmp_event_pkg::CTRL0_OFFSET, 8'h08);
		rd(cmp_event_pkg::CTRL0_OFFSET, 32'h08);
		`CHK("clock select", 1'b1, clk_sel)
		apb(1, cmp_event_pkg::CTRL0_OFFSET, 8'h00);
		// every negative-input code on comparator 2, positive at 0x70
		for (int k = 0; k < 8; k++) begin
			apb(1, cmp_event_pkg::CTRL2_OFFSET, 8'h80 | 8'(k));
			set_pos(2, 8'h70);
			`CHK("neg_sel", 3'(k), nsel[2])
			rd(ST, (8'hEA >> (7 - k)) & 8'h1 ? 32'h44 : 32'h0);
			apb(1, ST, 8'h40);
			set_pos(2, 8'h00);
			apb(1, ST, 8'h40);
		end
		apb(1, cmp_event_pkg::CTRL2_OFFSET, 8'h00);
	endtask
	task automatic t_sense();
		logic u;
		logic d;
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 4; s++) begin
				u = (s == 0) || (s == 3);
				d = (s == 0) || (s == 2);
				apb(1, 8'(4 * c), 8'h80 | 8'(s << 4));
				set_pos(c, 8'hFF);
				`CHK("trigger", u, trig[c])
				rd(ST, (32'(u) << (4 + c)) | 32'(1 << c));
				apb(1, ST, 8'(1 << (4 + c)));
				rd(ST, 32'(1 << c));
				set_pos(c, 8'h00);
				rd(ST, 32'(d) << (4 + c));
				apb(1, ST, 8'hF0);
			end
			apb(1, 8'(4 * c), 8'h00);
			set_pos(c, 8'hFF);
			rd(ST, 32'h0);
			set_pos(c, 8'h00);
		end
	endtask
	task automatic t_irq();
		apb(1, cmp_event_pkg::CTRL1_OFFSET, 8'hF0);
		set_pos(1, 8'hFF);
		`CHK("irq1", 1'b1, irq[1])
		apb(1, ST, 8'h00);
		rd(ST, 32'h22);
		ack(4'h2);
		rd(ST, 32'h02);
		`CHK("irq1 after ack", 1'b0, irq[1])
		apb(1, cmp_event_pkg::CTRL1_OFFSET, 8'hB0);
		set_pos(1, 8'h00);
		set_pos(1, 8'hFF);
		`CHK("irq1 masked", 1'b0, irq[1])
		ack(4'h2);
		rd(ST, 32'h22);
		apb(1, ST, 8'hF0);
		set_pos(1, 8'h00);
	endtask
	task automatic t_capture();
		mask <= 1;
		edge_sel <= 1;
		apb(1, cmp_event_pkg::CTRL1_OFFSET, 8'h88);
		set_pos(1, 8'hFF);
		set_pos(1, 8'h00);
		`CHK("rise events", 1, ev_cnt)
		`CHK("rise irqs", 1, irq_cnt)
		edge_sel <= 0;
		mask <= 0;
		set_pos(1, 8'hFF);
		set_pos(1, 8'h00);
		// the falling event pulses only as set_pos returns; let the counter see it
		repeat (2) @(posedge core_clk);
		`CHK("fall events", 2, ev_cnt)
		`CHK("masked irqs", 1, irq_cnt)
		nc <= 1;
		edge_sel <= 1;
		set_pos(1, 8'hFF);
		repeat (8) @(posedge core_clk);
		`CHK("filtered events", 3, ev_cnt)
		apb(1, cmp_event_pkg::CTRL1_OFFSET, 8'h80);
		set_pos(1, 8'h00);
		set_pos(1, 8'hFF);
		`CHK("unlinked input", 1'b0, cap_in)
		repeat (8) @(posedge core_clk);
		`CHK("unlinked events", 3, ev_cnt)
		apb(1, ST, 8'hF0);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		arst_n <= 1;
		t_regs();
		t_sense();
		t_irq();
		t_capture();
		end_of_test();
	end
endmodule
